// ==== verilog/capture_timer_pkg.sv ====
// Package for the capture/compare timer: register offsets, field positions,
// reset values, modes and small timing constants.
// Assumes an APB bus with 32-bit data, one register per aligned word.
package capture_timer_pkg;

	// --------------------------------------------------------------
	// Register indices as printed and the shift to their byte addresses
	// --------------------------------------------------------------
	localparam logic [7:0] IDX_CONTROL_A   = 8'h00;
	localparam logic [7:0] IDX_CONTROL_B   = 8'h01;
	localparam logic [7:0] IDX_EVENT_CTRL  = 8'h04;
	localparam logic [7:0] IDX_INT_ENABLE  = 8'h05;
	localparam logic [7:0] IDX_INT_FLAGS   = 8'h06;
	localparam logic [7:0] IDX_RUN_STATUS  = 8'h07;
	localparam logic [7:0] IDX_DEBUG_CTRL  = 8'h08;
	localparam logic [7:0] IDX_TEMP_BYTE   = 8'h09;
	localparam logic [7:0] IDX_COUNTER     = 8'h0A;
	localparam logic [7:0] IDX_CAPTURE_INTERRUPT_CMP    = 8'h0C;
	localparam int         ADDR_SHIFT      = 2;

	// --------------------------------------------------------------
	// Field positions
	// --------------------------------------------------------------
	localparam int BIT_ENABLE        = 0;
	localparam int BIT_CLOCK_SOURCE_SELECT_LO     = 1;
	localparam int BIT_SYNC_RESTART  = 4;
	localparam int BIT_RUN_STANDBY   = 6;
	localparam int BIT_MODE_LO       = 0;
	localparam int BIT_OUT_ENABLE    = 4;
	localparam int BIT_OUT_INIT      = 5;
	localparam int BIT_IMMEDIATE     = 6;
	localparam int BIT_EVENT_ENABLE  = 0;
	localparam int BIT_EDGE          = 4;
	localparam int BIT_FILTER        = 6;
	localparam int BIT_CAPTURE_INTERRUPT          = 0;

	// --------------------------------------------------------------
	// Reset values and constants
	// --------------------------------------------------------------
	localparam logic [7:0]  RESET_BYTE  = 8'h00;
	localparam logic [15:0] RESET_WORD  = 16'h0000;
	localparam int          FILTER_LEN  = 4;

	// Clock source selection
	typedef enum logic [1:0] {
		CLK_PERIPH  = 2'h0,
		CLK_HALF    = 2'h1,
		CLK_COMPAN  = 2'h2,
		CLK_RESVD   = 2'h3
	} clock_source_t;

	// Counter modes
	typedef enum logic [2:0] {
		MODE_PERIODIC  = 3'h0,
		MODE_TIMEOUT   = 3'h1,
		MODE_CAPTURE   = 3'h2,
		MODE_FREQ      = 3'h3,
		MODE_PWIDTH    = 3'h4,
		MODE_FREQ_PW   = 3'h5,
		MODE_SINGLE    = 3'h6,
		MODE_PWM8      = 3'h7
	} counter_mode_t;

	// Outputs that leave the timer together
	typedef struct packed {
		logic output_pin;
		logic event_pulse;
		logic irq;
	} timer_out_t;

endpackage : capture_timer_pkg

// ==== verilog/capture_timer_control_regs.sv ====
// Capture/compare timer with its control, mode and event configuration.
// Assumes an APB master on clock, an event channel input and companion
// timer signals arriving asynchronously (synchronised here).
`timescale 1ns/1ps

module capture_timer_control_regs (
	// Clock and reset
	input  wire logic                          clock,
	input  wire logic                          rst,
	// APB slave
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [11:0]                   paddr,
	input  wire logic [31:0]                   pwdata,
	output logic      [31:0]                   prdata,
	output logic                               pready,
	output logic                               pslverr,
	// Event channel and companion timer, asynchronous
	input  wire logic                          event_in,
	input  wire logic                          companion_tick,
	input  wire logic                          companion_restart,
	// System state
	input  wire logic                          standby,
	input  wire logic                          debug_halt,
	// Timer outputs
	output capture_timer_pkg::timer_out_t      timer_out
);

	// --------------------------------------------------------------
	// Registers
	// --------------------------------------------------------------
	logic [7:0]  control_a_q;       // Enable, clock select, sync, standby
	logic [7:0]  control_b_q;       // Mode and output options
	logic [7:0]  event_control_q;   // Event enable, edge, filter
	logic        int_enable_q;      // Capture interrupt enable
	logic        capture_interrupt_flag_q;       // Capture interrupt flag
	logic        run_while_debug_halted_q;
	logic [7:0]  temp_q;            // Temporary byte, plain storage
	logic [15:0] count_q;           // Counter
	logic [15:0] capture_compare_value_q;            // Capture/compare
	logic        running_q;         // Counter running
	logic        out_q;             // Mode-generated output level
	logic        half_q;            // Half-rate toggle
	logic        fpw_armed_q;       // Freq+width: first edge seen
	logic        ss_pending_q;      // Single-shot start pending
	logic [1:0]  ss_delay_q;        // Single-shot start delay
	logic        was_enabled_q;     // Enable edge detect

	// Synchronisers: first stage read only by second stage
	logic [1:0]  ev_sync_q;
	logic [1:0]  tick_sync_q;
	logic [1:0]  rst_sync_q;
	logic        tick_prev_q;
	logic        rst_prev_q;
	logic [capture_timer_pkg::FILTER_LEN-1:0] ev_hist_q;  // Filter history
	logic        ev_level_q;        // Filtered/used event level

	// Field views
	logic                            enable;
	capture_timer_pkg::clock_source_t clk_src;
	capture_timer_pkg::counter_mode_t mode;
	logic                            edge_sel;
	logic                            ev_en;

	assign enable   = control_a_q[capture_timer_pkg::BIT_ENABLE];
	assign clk_src  = capture_timer_pkg::clock_source_t'(
		control_a_q[capture_timer_pkg::BIT_CLOCK_SOURCE_SELECT_LO +: 2]);
	assign mode     = capture_timer_pkg::counter_mode_t'(
		control_b_q[capture_timer_pkg::BIT_MODE_LO +: 3]);
	assign edge_sel = event_control_q[capture_timer_pkg::BIT_EDGE];
	assign ev_en    = event_control_q[capture_timer_pkg::BIT_EVENT_ENABLE];

	// --------------------------------------------------------------
	// APB decode
	// --------------------------------------------------------------
	logic        acc_go;            // Access phase, one cycle
	logic        wr_go;
	logic        rd_go;
	logic [9:0]  widx;              // Word index
	logic [7:0]  wb;                // Write byte
	logic [15:0] ww;                // Write word
	logic        mapped;

	assign acc_go = psel & penable & ~pready;
	assign wr_go  = acc_go & pwrite;
	assign rd_go  = acc_go & ~pwrite;
	assign widx   = paddr[11:capture_timer_pkg::ADDR_SHIFT];
	assign wb     = pwdata[7:0];
	assign ww     = pwdata[15:0];

	// Decode of the printed indices
	always_comb begin
		unique case (widx[7:0])
			capture_timer_pkg::IDX_CONTROL_A, capture_timer_pkg::IDX_CONTROL_B,
			capture_timer_pkg::IDX_EVENT_CTRL, capture_timer_pkg::IDX_INT_ENABLE,
			capture_timer_pkg::IDX_INT_FLAGS, capture_timer_pkg::IDX_RUN_STATUS,
			capture_timer_pkg::IDX_DEBUG_CTRL, capture_timer_pkg::IDX_TEMP_BYTE,
			capture_timer_pkg::IDX_COUNTER, capture_timer_pkg::IDX_CAPTURE_INTERRUPT_CMP:
				mapped = (widx[9:8] == 2'h0);
			default:
				mapped = 1'b0;
		endcase
	end

	// --------------------------------------------------------------
	// Input synchronisers and noise canceller
	// --------------------------------------------------------------
	// Two flops per asynchronous input before any logic looks at it
	always_ff @(posedge clock) begin
		if (rst) begin
			ev_sync_q   <= 2'h0;
			tick_sync_q <= 2'h0;
			rst_sync_q  <= 2'h0;
			tick_prev_q <= 1'b0;
			rst_prev_q  <= 1'b0;
		end else begin
			ev_sync_q   <= {ev_sync_q[0], event_in};
			tick_sync_q <= {tick_sync_q[0], companion_tick};
			rst_sync_q  <= {rst_sync_q[0], companion_restart};
			tick_prev_q <= tick_sync_q[1];
			rst_prev_q  <= rst_sync_q[1];
		end
	end

	// Filter keeps four samples; level moves only when all agree
	always_ff @(posedge clock) begin
		if (rst) begin
			ev_hist_q  <= 4'h0;
			ev_level_q <= 1'b0;
		end else begin
			ev_hist_q <= {ev_hist_q[2:0], ev_sync_q[1]};
			if (!event_control_q[capture_timer_pkg::BIT_FILTER]) begin
				ev_level_q <= ev_sync_q[1];
			end else if (&ev_hist_q) begin
				ev_level_q <= 1'b1;
			end else if (~|ev_hist_q) begin
				ev_level_q <= 1'b0;
			end
		end
	end

	// --------------------------------------------------------------
	// Edge detection and activity
	// --------------------------------------------------------------
	logic ev_prev_q;
	logic pos_edge;
	logic neg_edge;
	logic sel_edge;                 // Edge chosen by edge-select
	logic opp_edge;
	logic active;                   // Timer allowed to do anything
	logic tick;                     // Counting clock strobe
	logic comp_restart;

	always_ff @(posedge clock) begin
		if (rst) begin
			ev_prev_q <= 1'b0;
		end else begin
			ev_prev_q <= ev_level_q;
		end
	end

	// Events count only with input enable; standby/debug freeze below
	assign pos_edge = ev_en & ev_level_q & ~ev_prev_q;
	assign neg_edge = ev_en & ~ev_level_q & ev_prev_q;
	assign sel_edge = edge_sel ? neg_edge : pos_edge;
	assign opp_edge = edge_sel ? pos_edge : neg_edge;

	// Standby halts unless run-in-standby; companion clock ignores it
	assign active = enable
		& (~standby | control_a_q[capture_timer_pkg::BIT_RUN_STANDBY]
			| (clk_src == capture_timer_pkg::CLK_COMPAN))
		& (~debug_halt | run_while_debug_halted_q);

	// Prescaled count strobe
	always_comb begin
		unique case (clk_src)
			capture_timer_pkg::CLK_PERIPH: tick = 1'b1;
			capture_timer_pkg::CLK_HALF:   tick = half_q;
			capture_timer_pkg::CLK_COMPAN: tick = tick_sync_q[1] & ~tick_prev_q;
			capture_timer_pkg::CLK_RESVD:  tick = 1'b0;
		endcase
	end

	// Restart only while active: a disabled timer must keep its count
	assign comp_restart = active & control_a_q[capture_timer_pkg::BIT_SYNC_RESTART]
		& rst_sync_q[1] & ~rst_prev_q;

	always_ff @(posedge clock) begin
		if (rst) begin
			half_q <= 1'b0;
		end else begin
			half_q <= active ? ~half_q : 1'b0;
		end
	end

	// --------------------------------------------------------------
	// Mode engine: counter, capture, flag, output
	// --------------------------------------------------------------
	logic [15:0] top_val;
	logic        at_top;
	logic        set_flag;          // Flag set condition this cycle
	logic        do_capture;
	logic        do_restart;
	logic        do_start;
	logic        do_stop;
	logic        ss_trigger;

	assign top_val = (mode == capture_timer_pkg::MODE_PWM8) ? {8'h00, capture_compare_value_q[7:0]} : capture_compare_value_q;
	assign at_top  = running_q & tick & (count_q == top_val);
	// Single-shot: edge-select one fires on both polarities
	assign ss_trigger = edge_sel ? (pos_edge | neg_edge) : pos_edge;

	always_comb begin
		do_capture = 1'b0;
		do_restart = 1'b0;
		do_start   = 1'b0;
		do_stop    = 1'b0;
		set_flag   = 1'b0;
		if (active) begin
			unique case (mode)
				capture_timer_pkg::MODE_PERIODIC: begin
					// Edges ignored, flag at top
					set_flag = at_top;
				end
				capture_timer_pkg::MODE_TIMEOUT: begin
					do_start = sel_edge;
					do_stop  = opp_edge;
					set_flag = at_top;
				end
				capture_timer_pkg::MODE_CAPTURE: begin
					do_capture = sel_edge;
					set_flag   = sel_edge;
				end
				capture_timer_pkg::MODE_FREQ: begin
					do_capture = sel_edge;
					do_restart = sel_edge;
					set_flag   = sel_edge;
				end
				capture_timer_pkg::MODE_PWIDTH: begin
					do_restart = sel_edge;
					do_capture = opp_edge;
					set_flag   = opp_edge;
				end
				capture_timer_pkg::MODE_FREQ_PW: begin
					// Wait until the previous result is read or cleared
					if (!capture_interrupt_flag_q) begin
						do_restart = sel_edge & ~fpw_armed_q;
						do_capture = opp_edge & fpw_armed_q;
						do_stop    = sel_edge & fpw_armed_q;
						set_flag   = sel_edge & fpw_armed_q;
					end
				end
				capture_timer_pkg::MODE_SINGLE: begin
					set_flag = at_top;
				end
				capture_timer_pkg::MODE_PWM8: begin
					set_flag = at_top;
				end
			endcase
		end
	end

	// Freq+width sequence state
	always_ff @(posedge clock) begin
		if (rst) begin
			fpw_armed_q <= 1'b0;
		end else if (mode != capture_timer_pkg::MODE_FREQ_PW || !active) begin
			fpw_armed_q <= 1'b0;
		end else if (do_restart) begin
			fpw_armed_q <= 1'b1;
		end else if (do_stop) begin
			fpw_armed_q <= 1'b0;
		end
	end

	// Single-shot start: two-cycle delay, trigger ignored while busy
	always_ff @(posedge clock) begin
		if (rst) begin
			ss_pending_q <= 1'b0;
			ss_delay_q   <= 2'h0;
		end else if (!active || mode != capture_timer_pkg::MODE_SINGLE) begin
			ss_pending_q <= 1'b0;
			ss_delay_q   <= 2'h0;
		end else if (ss_pending_q) begin
			ss_delay_q   <= ss_delay_q + 2'h1;
			ss_pending_q <= (ss_delay_q == 2'h0);
		end else if (ss_trigger && !running_q) begin
			ss_pending_q <= 1'b1;
			ss_delay_q   <= 2'h0;
		end
	end

	logic ss_go;
	assign ss_go = ss_pending_q & (ss_delay_q == 2'h1);

	// Counter; bus write has priority over internal updates
	always_ff @(posedge clock) begin
		if (rst) begin
			count_q <= capture_timer_pkg::RESET_WORD;
		end else if (wr_go && mapped && widx[7:0] == capture_timer_pkg::IDX_COUNTER) begin
			count_q <= ww;
		end else if (do_restart || comp_restart || ss_go) begin
			count_q <= 16'h0000;
		end else if (at_top && mode != capture_timer_pkg::MODE_SINGLE) begin
			count_q <= 16'h0000;
		end else if (running_q && tick && active && !at_top) begin
			count_q <= count_q + 16'h0001;
		end
	end

	// Run state
	always_ff @(posedge clock) begin
		if (rst) begin
			running_q <= 1'b0;
		end else if (!enable) begin
			running_q <= 1'b0;
		end else if (!was_enabled_q) begin
			// Counter starts as soon as the block is enabled, except in timeout mode
			running_q <= (mode != capture_timer_pkg::MODE_TIMEOUT);
		end else if (do_stop || (at_top && mode == capture_timer_pkg::MODE_SINGLE)) begin
			running_q <= 1'b0;
		end else if (do_start || do_restart || ss_go) begin
			running_q <= 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			was_enabled_q <= 1'b0;
		end else begin
			was_enabled_q <= enable;
		end
	end

	// Capture/compare register; software writes win
	always_ff @(posedge clock) begin
		if (rst) begin
			capture_compare_value_q <= capture_timer_pkg::RESET_WORD;
		end else if (wr_go && mapped && widx[7:0] == capture_timer_pkg::IDX_CAPTURE_INTERRUPT_CMP) begin
			capture_compare_value_q <= ww;
		end else if (do_capture) begin
			capture_compare_value_q <= count_q;
		end
	end

	// Mode output level
	always_ff @(posedge clock) begin
		if (rst) begin
			out_q <= 1'b0;
		end else if (!enable) begin
			out_q <= control_b_q[capture_timer_pkg::BIT_OUT_INIT];
		end else if (mode == capture_timer_pkg::MODE_SINGLE) begin
			if (control_b_q[capture_timer_pkg::BIT_IMMEDIATE] && ss_trigger
				&& !running_q && active) begin
				out_q <= 1'b1;
			end else if (ss_go) begin
				out_q <= 1'b1;
			end else if (at_top) begin
				out_q <= 1'b0;
			end
		end else if (mode == capture_timer_pkg::MODE_PWM8 && active && tick) begin
			// Decide on the count about to be shown, so the level is high for
			// exactly the high-byte number of counts in each period
			if (at_top) begin
				out_q <= (capture_compare_value_q[15:8] != 8'h00) && (capture_compare_value_q[7:0] != 8'h00);
			end else if (count_q[7:0] + 8'h01 == capture_compare_value_q[15:8]) begin
				out_q <= 1'b0;
			end
		end
	end

	// Capture flag: set wins over write-one or read clear
	logic capture_interrupt_read;
	assign capture_interrupt_read = rd_go && mapped && widx[7:0] == capture_timer_pkg::IDX_CAPTURE_INTERRUPT_CMP
		&& (mode inside {capture_timer_pkg::MODE_CAPTURE, capture_timer_pkg::MODE_FREQ,
			capture_timer_pkg::MODE_PWIDTH, capture_timer_pkg::MODE_FREQ_PW});

	always_ff @(posedge clock) begin
		if (rst) begin
			capture_interrupt_flag_q <= 1'b0;
		end else if (set_flag) begin
			capture_interrupt_flag_q <= 1'b1;
		end else if (capture_interrupt_read || (wr_go && mapped
			&& widx[7:0] == capture_timer_pkg::IDX_INT_FLAGS
			&& wb[capture_timer_pkg::BIT_CAPTURE_INTERRUPT])) begin
			capture_interrupt_flag_q <= 1'b0;
		end
	end

	// --------------------------------------------------------------
	// Control register writes
	// --------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (rst) begin
			control_a_q              <= capture_timer_pkg::RESET_BYTE;
			control_b_q              <= capture_timer_pkg::RESET_BYTE;
			event_control_q          <= capture_timer_pkg::RESET_BYTE;
			int_enable_q             <= 1'b0;
			run_while_debug_halted_q <= 1'b0;
			temp_q                   <= capture_timer_pkg::RESET_BYTE;
		end else if (wr_go && mapped) begin
			unique case (widx[7:0])
				capture_timer_pkg::IDX_CONTROL_A:  control_a_q     <= wb & 8'h57;
				capture_timer_pkg::IDX_CONTROL_B:  control_b_q     <= wb & 8'h77;
				capture_timer_pkg::IDX_EVENT_CTRL: event_control_q <= wb & 8'h51;
				capture_timer_pkg::IDX_INT_ENABLE: int_enable_q    <= wb[0];
				capture_timer_pkg::IDX_DEBUG_CTRL: run_while_debug_halted_q <= wb[0];
				capture_timer_pkg::IDX_TEMP_BYTE:  temp_q          <= wb;
				default: ;
			endcase
		end
	end

	// --------------------------------------------------------------
	// APB response: one wait state per access phase, registered
	// --------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= acc_go;
			pslverr <= acc_go & ~mapped;
			if (rd_go && mapped) begin
				unique case (widx[7:0])
					capture_timer_pkg::IDX_CONTROL_A:  prdata <= {24'h0, control_a_q};
					capture_timer_pkg::IDX_CONTROL_B:  prdata <= {24'h0, control_b_q};
					capture_timer_pkg::IDX_EVENT_CTRL: prdata <= {24'h0, event_control_q};
					capture_timer_pkg::IDX_INT_ENABLE: prdata <= {31'h0, int_enable_q};
					capture_timer_pkg::IDX_INT_FLAGS:  prdata <= {31'h0, capture_interrupt_flag_q};
					capture_timer_pkg::IDX_RUN_STATUS: prdata <= {31'h0, running_q};
					capture_timer_pkg::IDX_DEBUG_CTRL:
						prdata <= {31'h0, run_while_debug_halted_q};
					capture_timer_pkg::IDX_TEMP_BYTE:  prdata <= {24'h0, temp_q};
					capture_timer_pkg::IDX_COUNTER:    prdata <= {16'h0, count_q};
					default:                           prdata <= {16'h0, capture_compare_value_q};
				endcase
			end else begin
				prdata <= 32'h0000_0000;
			end
		end
	end

	// --------------------------------------------------------------
	// Outputs, all registered
	// --------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (rst) begin
			timer_out <= '0;
		end else begin
			timer_out.output_pin  <= out_q & control_b_q[capture_timer_pkg::BIT_OUT_ENABLE];
			timer_out.event_pulse <= set_flag;
			timer_out.irq         <= int_enable_q & (capture_interrupt_flag_q | set_flag);
		end
	end

endmodule : capture_timer_control_regs

// ==== verification/capture_timer_control_regs_sva.sv ====
// Checker for the timer's bus handshake, reset and interrupt ports.
// Assumes a master that only uses word-aligned addresses.
`timescale 1ns/1ps
module timer_checker (
	// Clock and reset
	input wire logic                          clock,
	input wire logic                          rst,
	// Bus
	input wire logic                          psel,
	input wire logic                          penable,
	input wire logic [11:0]                   paddr,
	input wire logic [31:0]                   prdata,
	input wire logic                          pready,
	input wire logic                          pslverr,
	// Timer outputs
	input wire capture_timer_pkg::timer_out_t timer_out
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	logic mapped;	// Word index names a register
	assign mapped = paddr[11:2] inside {0, 1, 4, 5, 6, 7, 8, 9, 10, 12};
	ready_wait_a: assert property (psel && penable && !pready |=> pready) else $error("pready late");
	ready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
	ready_acc_a: assert property (pready |-> psel && penable) else $error("pready off access");
	rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero");
	err_map_a: assert property (pready |-> pslverr == !mapped) else $error("pslverr wrong");
	err_data_a: assert property (pslverr |-> prdata == 32'h0) else $error("bad read data");
	rst_clear_a: assert property ($past(rst) |-> timer_out == 3'h0 && !pready)
		else $error("outputs not cleared");
	irq_fall_a: assert property ($fell(timer_out.irq) && !$past(rst) |-> $past(pready))
		else $error("irq fell without access");
endmodule : timer_checker

bind capture_timer_control_regs timer_checker chk (.clock(clock), .rst(rst), .psel(psel),
	.penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.timer_out(timer_out));

// ==== verification/event_partner.sv ====
// Model of the event channel and the companion type-A timer.
// Assumes the bench requests event levels on the shared clock.
`timescale 1ns/1ps
module event_partner (
	// Clock, reset and requested level
	input  wire logic clock,
	input  wire logic rst,
	input  wire logic lvl,
	// Lines into the timer
	output logic      event_in = 1'b0,
	output logic      companion_tick = 1'b0,
	output logic      companion_restart = 1'b0
);
	logic [5:0] cnt_q = 6'h00;	// Companion counter, free running
	// Event level held whole cycles so it is never too short to see
	always @(posedge clock) begin
		event_in <= lvl;
	end
	// Companion runs on regardless of the timer, as the real one does
	always @(posedge clock) begin
		cnt_q <= rst ? 6'h00 : cnt_q + 6'h01;
		companion_tick <= cnt_q[0];
		companion_restart <= (cnt_q == 6'h3F);
	end
endmodule : event_partner

// ==== verification/capture_timer_control_regs_test.sv ====
// Self-checking bench for the capture/compare timer.
// Assumes the event partner and the bound checker are compiled alongside.
`timescale 1ns/1ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin n_errors++; \
	$display("wrong value %s exp %0h got %0h", n, e, s); end end
module capture_timer_control_regs_test;
	logic        clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic        lvl = 1'b0, sb = 1'b0, pready, pslverr, errv, ev, tick, rs;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rdv;
	capture_timer_pkg::timer_out_t tout;
	int          n_errors = 0, num_checks = 0, cyc = 0, npulse = 0, hi, i, k;
	int          msk[13] = '{'h57, 'h77, 0, 0, 'h51, 1, 0, 0, 1, 'hFF, 'hFFFF, 0, 'hFFFF};
	int          idx[10] = '{0, 1, 4, 5, 6, 7, 8, 9, 10, 12};
	int          mdl[13];	// Register model, reset values all zero
	capture_timer_control_regs DUT (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .event_in(ev), .companion_tick(tick), .companion_restart(rs),
		.standby(sb), .debug_halt(1'b0), .timer_out(tout));
	event_partner ptn (.clock(clock), .rst(rst), .lvl(lvl), .event_in(ev),
		.companion_tick(tick), .companion_restart(rs));
	initial begin
		forever #5 clock = ~clock;
	end
	// Cycle ceiling and event output pulse counter
	always @(posedge clock) begin
		cyc++;
		npulse += (tout.event_pulse === 1'b1);
		if (cyc == 20000) begin
			n_errors++;
			end_sim();
		end
	end
	// One APB transfer; held until pready is seen high
	task automatic acc(input logic w, input int a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= 12'(a * 4);
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : acc
	task automatic wrm(input int a, input int d);
		acc(1'b1, a, d);
		mdl[a] = d & msk[a];
	endtask : wrm
	task automatic chkrd(input int a, input int e);
		acc(1'b0, a, 0);
		`CHK("register", e, rdv)
	endtask : chkrd
	task end_sim;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_sim
	initial begin
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		void'($urandom(43));
		foreach (idx[j]) chkrd(idx[j], 0);
		// Random writes with the timer held off; bit 0 of control A stays clear
		for (k = 0; k < 40; k++) begin
			i = idx[$urandom_range(9)];
			wrm(i, i == 0 ? ($urandom() & 32'hFFFF_FFFE) : $urandom());
			chkrd(i, mdl[i]);
		end
		acc(1'b1, 2, 32'hFF);
		`CHK("slverr", 1'b1, errv)
		chkrd(2, 0);
		$display("test registers done");
		wrm(1, 2);
		wrm(5, 1);
		wrm(0, 1);
		// Capture: input enable against edge select plus filter, in all four pairings
		for (i = 0; i < 4; i++) begin
			wrm(6, 1);
			wrm(4, (i % 2) * 'h50 + i / 2);
			lvl <= 1'b1;
			repeat (12) @(posedge clock);
			chkrd(6, (i / 2) * (1 - i % 2));
			`CHK("irq", (i / 2) * (1 - i % 2), tout.irq)
			lvl <= 1'b0;
			repeat (12) @(posedge clock);
			chkrd(6, i / 2);
			`CHK("irq", i / 2, tout.irq)
		end
		acc(1'b0, 12, 0);
		chkrd(6, 0);
		`CHK("pulses", 2, npulse)
		$display("test capture done");
		wrm(0, 0);
		wrm(12, 'h0204);
		// PWM duty over whole periods, full and half rate, output on and off
		for (i = 0; i < 4; i++) begin
			wrm(0, 0);
			wrm(10, 0);
			wrm(1, 'h07 + (i % 2) * 'h10);
			wrm(0, 1 + (i / 2) * 2);
			repeat (10) @(posedge clock);
			hi = 0;
			repeat (50) begin
				@(posedge clock);
				hi += (tout.output_pin === 1'b1);
			end
			`CHK("duty", 20 * (i % 2), hi)
		end
		$display("test pwm done");
		// Standby freezes the count unless run-in-standby or companion clock
		wrm(1, 0);
		wrm(12, 'hFFFF);
		for (i = 0; i < 3; i++) begin
			wrm(0, i == 0 ? 'h01 : (i == 1 ? 'h41 : 'h05));
			sb <= 1'b1;
			acc(1'b0, 10, 0);
			hi = rdv;
			repeat (8) @(posedge clock);
			acc(1'b0, 10, 0);
			`CHK("moving", i > 0, rdv != hi)
			sb <= 1'b0;
		end
		// Reserved clock holds the count; sync bit lets the companion restart it
		for (i = 0; i < 2; i++) begin
			wrm(0, 0);
			wrm(10, 5);
			wrm(0, 'h07 + i * 'h10);
			repeat (70) @(posedge clock);
			chkrd(10, 5 * (1 - i));
		end
		$display("test standby done");
		// Idle timer shows the initial level through the output enable
		wrm(0, 0);
		for (i = 0; i < 2; i++) begin
			wrm(1, 'h10 + i * 'h20);
			repeat (3) @(posedge clock);
			`CHK("init level", i, tout.output_pin)
		end
		$display("test init level done");
		end_sim();
	end
endmodule : capture_timer_control_regs_test
